// File: design/tcc_pkg.sv
// constants for the 16-bit timer counter with input capture
// assumes an 8-bit register port and a timer tick supplied from outside
//
// What this block does
// - 16-bit up/down counter with clear; flags top and zero
// - high byte goes via shared temp; low read loads temp, low write commits
// - clock select zero stops the counter
// - counter stays readable and writable with or without ticks
// - cpu write beats clear, increment and decrement in the same cycle
// - counting follows four-bit mode field; overflow flag set per mode
// - qualified edge copies counter to capture register and sets flag
// - flag raises irq when enabled; cleared by service ack or written one
// - capture low read copies high byte into temp for later high read
// - capture register writable only in modes using it as top
// - comparator select switches trigger source; switch may capture
// - inputs synchronised; noise filter adds four cycles of delay
// - filter and edge detector idle in modes with capture as top
// - port driving the capture pin triggers capture like an edge
// - filter output changes only after four equal samples
// - filter enabled by control b bit, samples on system clock
// - new capture overwrites unread capture value
// - write high then low, read low then high; low access transfers
// - bottom is 0x0000, max 0xFFFF, top fixed or from register
// - one 8-bit temp register serves all 16-bit registers
package tcc_pkg;
    localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B     = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LOW  = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
    localparam logic [3:0] ADDR_CAPT_LOW   = 4'h4;
    localparam logic [3:0] ADDR_CAPT_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_FLAGS      = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h7;
    localparam logic [3:0] ADDR_CMP_CTRL   = 4'h8;
    // control a: mode bits 1:0; control b: clock select 2:0, mode 4:3,
    // edge select 6, filter enable 7
    localparam int         CSEL_LSB        = 0;
    localparam int         WGM_HI_LSB      = 3;
    localparam int         EDGE_BIT        = 6;
    localparam int         FILT_BIT        = 7;
    localparam int         OVF_BIT         = 0;
    localparam int         CAPT_BIT        = 5;
    localparam int         CMPSEL_BIT      = 2;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [15:0] BOTTOM_VALUE   = 16'h0000;
    localparam logic [15:0] MAX_VALUE      = 16'hFFFF;
    localparam int         FILT_SAMPLES    = 4;
    localparam logic [7:0] READ_NONE       = 8'h00;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } tcc_dir_t;

    // modes 8, 10, 12, 14 take top from the capture register
    function automatic logic tcc_capt_is_top(input logic [3:0] wgm);
        return (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC)
            || (wgm == 4'hE);
    endfunction

    function automatic logic [15:0] tcc_top(input logic [3:0] wgm,
                                            input logic [15:0] capt);
        unique case (wgm)
            4'h1, 4'h5:  return 16'h00FF;
            4'h2, 4'h6:  return 16'h01FF;
            4'h3, 4'h7:  return 16'h03FF;
            4'h8, 4'hA, 4'hC, 4'hE: return capt;
            default:     return 16'hFFFF;
        endcase
    endfunction

    // dual-slope modes count up then down
    function automatic logic tcc_dual_slope(input logic [3:0] wgm);
        return (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3)
            || (wgm == 4'h8) || (wgm == 4'hA);
    endfunction
endpackage

// File: design/tcc_edge_if.sv
// edge path carrier between the timer top and the input filter
// assumes one system clock shared by both ends
`timescale 1ns/100ps
interface tcc_edge_if;
    logic rawIn;
    logic filtEn;
    logic enable;
    logic level;

    modport ctrl
    (
        output rawIn,
        output filtEn,
        output enable,
        input  level
    );
    modport filt
    (
        input  rawIn,
        input  filtEn,
        input  enable,
        output level
    );
endinterface

// File: design/tcc_input_filter.sv
// synchroniser and four-sample noise filter for the capture source
// assumes the source is synchronous-ish and sampled on clk_sys
`timescale 1ns/100ps
module tcc_input_filter
(
    input  wire logic clk_sys,
    input  wire logic reset,
    tcc_edge_if.filt  edgeBus
);
    logic [1:0] syncQ;
    logic [1:0] syncD;
    logic [3:0] histQ;
    logic [3:0] histD;
    logic       levelQ;
    logic       levelD;

    always_comb
    begin
        syncD  = {syncQ[0], edgeBus.rawIn};
        histD  = {histQ[2:0], syncQ[1]};
        levelD = levelQ;
        if (!edgeBus.enable)
            levelD = levelQ;
        else if (!edgeBus.filtEn)
            levelD = syncQ[1];
        else if (histQ == 4'hF)
            levelD = 1'b1;
        else if (histQ == 4'h0)
            levelD = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            syncQ  <= 2'h0;
            histQ  <= 4'h0;
            levelQ <= 1'b0;
        end
        else
        begin
            syncQ  <= syncD;
            histQ  <= histD;
            levelQ <= levelD;
        end
    end

    assign edgeBus.level = levelQ;

    a_filter_four_equal: assert property (@(posedge clk_sys) disable iff
        (reset) (edgeBus.enable && edgeBus.filtEn && $changed(levelQ))
        |-> ($past(histQ) == {4{levelQ}}))
        else $error("filter changed without four equal samples");
endmodule // tcc_input_filter

// File: design/tcc_timer.sv
// 16-bit timer counter with input capture and 8-bit register port
// assumes tick pulses come from an outside prescaler, one cycle each
`timescale 1ns/100ps
module tcc_timer
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       timerTick,
    input  wire logic       captureInputPin,
    input  wire logic       comparatorOutput,
    input  wire logic       captureIrqAck,
    output logic            captureIrq,
    output logic            overflowIrq,
    output logic            atTop,
    output logic            atBottom
);
    logic [7:0]  ctrlAQ, ctrlAD, ctrlBQ, ctrlBD, cmpCtrlQ, cmpCtrlD;
    logic [7:0]  maskQ, maskD, tempQ, tempD, rdQ, rdD;
    logic [15:0] countQ, countD, captQ, captD;
    logic        ovfQ, ovfD, captFlagQ, captFlagD;
    logic        dirQ, dirD, levelQ, levelD;
    logic        topQ, topD, botQ, botD, cIrqQ, cIrqD, oIrqQ, oIrqD;
    logic [3:0]  wgm;
    logic [15:0] topVal;
    logic        captEdge, flagWrite;
    tcc_edge_if  edgeBus();

    assign wgm    = {ctrlBQ[tcc_pkg::WGM_HI_LSB +: 2], ctrlAQ[1:0]};
    assign topVal = tcc_pkg::tcc_top(wgm, captQ);

    // source select; pin value includes whatever the port drives on it
    assign edgeBus.rawIn  = cmpCtrlQ[tcc_pkg::CMPSEL_BIT] ?
                            comparatorOutput : captureInputPin;
    assign edgeBus.filtEn = ctrlBQ[tcc_pkg::FILT_BIT];
    assign edgeBus.enable = !tcc_pkg::tcc_capt_is_top(wgm);

    tcc_input_filter uFilter
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .edgeBus (edgeBus)
    );

    // edge select one means rising edge
    assign captEdge = edgeBus.enable && (edgeBus.level != levelQ)
        && (edgeBus.level == ctrlBQ[tcc_pkg::EDGE_BIT]);
    assign flagWrite = regWrite && (regAddr == tcc_pkg::ADDR_FLAGS);

    always_comb
    begin
        ctrlAD   = ctrlAQ;
        ctrlBD   = ctrlBQ;
        cmpCtrlD = cmpCtrlQ;
        maskD    = maskQ;
        tempD    = tempQ;
        countD   = countQ;
        captD    = captQ;
        dirD     = dirQ;
        ovfD     = ovfQ;
        captFlagD = captFlagQ;
        levelD   = edgeBus.level;
        rdD      = tcc_pkg::READ_NONE;

        // counting on ticks only, stopped with clock select zero
        if (timerTick && ctrlBQ[tcc_pkg::CSEL_LSB +: 3] != 3'h0)
        begin
            if (tcc_pkg::tcc_dual_slope(wgm))
            begin
                if (dirQ == tcc_pkg::DIR_UP)
                begin
                    if (countQ >= topVal)
                    begin
                        dirD   = tcc_pkg::DIR_DOWN;
                        countD = countQ - 16'h0001;
                    end
                    else
                        countD = countQ + 16'h0001;
                end
                else if (countQ == tcc_pkg::BOTTOM_VALUE)
                begin
                    dirD   = tcc_pkg::DIR_UP;
                    countD = countQ + 16'h0001;
                    ovfD   = 1'b1;
                end
                else
                    countD = countQ - 16'h0001;
            end
            else if (countQ == topVal)
            begin
                countD = tcc_pkg::BOTTOM_VALUE;
                ovfD   = 1'b1;
            end
            else
                countD = countQ + 16'h0001;
        end

        if (captEdge)
        begin
            captD     = countQ;
        end

        if (flagWrite && regWrData[tcc_pkg::OVF_BIT])
            ovfD = 1'b0;
        if ((flagWrite && regWrData[tcc_pkg::CAPT_BIT]) || captureIrqAck)
            captFlagD = 1'b0;
        if (captEdge)
            captFlagD = 1'b1;

        if (regWrite)
        begin
            unique case (regAddr)
                tcc_pkg::ADDR_CTRL_A:    ctrlAD   = regWrData;
                tcc_pkg::ADDR_CTRL_B:    ctrlBD   = regWrData;
                tcc_pkg::ADDR_CMP_CTRL:  cmpCtrlD = regWrData;
                tcc_pkg::ADDR_IRQ_MASK:  maskD    = regWrData;
                tcc_pkg::ADDR_COUNT_HIGH,
                tcc_pkg::ADDR_CAPT_HIGH: tempD    = regWrData;
                tcc_pkg::ADDR_COUNT_LOW:
                    countD = {tempQ, regWrData};
                tcc_pkg::ADDR_CAPT_LOW:
                    if (tcc_pkg::tcc_capt_is_top(wgm))
                        captD = {tempQ, regWrData};
                default: ;
            endcase
        end
        else if (regRead)
        begin
            unique case (regAddr)
                tcc_pkg::ADDR_CTRL_A:   rdD = ctrlAQ;
                tcc_pkg::ADDR_CTRL_B:   rdD = ctrlBQ;
                tcc_pkg::ADDR_CMP_CTRL: rdD = cmpCtrlQ;
                tcc_pkg::ADDR_IRQ_MASK: rdD = maskQ;
                tcc_pkg::ADDR_FLAGS:
                    rdD = {2'h0, captFlagQ, 4'h0, ovfQ};
                tcc_pkg::ADDR_COUNT_LOW:
                begin
                    rdD   = countQ[7:0];
                    tempD = countQ[15:8];
                end
                tcc_pkg::ADDR_CAPT_LOW:
                begin
                    rdD   = captQ[7:0];
                    tempD = captQ[15:8];
                end
                tcc_pkg::ADDR_COUNT_HIGH,
                tcc_pkg::ADDR_CAPT_HIGH: rdD = tempQ;
                default: rdD = tcc_pkg::READ_NONE;
            endcase
        end

        topD  = (countD == topVal);
        botD  = (countD == tcc_pkg::BOTTOM_VALUE);
        cIrqD = captFlagD && maskD[tcc_pkg::CAPT_BIT];
        oIrqD = ovfD && maskD[tcc_pkg::OVF_BIT];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrlAQ    <= tcc_pkg::CTRL_RESET;
            ctrlBQ    <= tcc_pkg::CTRL_RESET;
            cmpCtrlQ  <= tcc_pkg::CTRL_RESET;
            maskQ     <= tcc_pkg::CTRL_RESET;
            tempQ     <= 8'h00;
            countQ    <= tcc_pkg::BOTTOM_VALUE;
            captQ     <= tcc_pkg::BOTTOM_VALUE;
            dirQ      <= tcc_pkg::DIR_UP;
            ovfQ      <= 1'b0;
            captFlagQ <= 1'b0;
            levelQ    <= 1'b0;
            rdQ       <= tcc_pkg::READ_NONE;
            topQ      <= 1'b0;
            botQ      <= 1'b1;
            cIrqQ     <= 1'b0;
            oIrqQ     <= 1'b0;
        end
        else
        begin
            ctrlAQ    <= ctrlAD;
            ctrlBQ    <= ctrlBD;
            cmpCtrlQ  <= cmpCtrlD;
            maskQ     <= maskD;
            tempQ     <= tempD;
            countQ    <= countD;
            captQ     <= captD;
            dirQ      <= dirD;
            ovfQ      <= ovfD;
            captFlagQ <= captFlagD;
            levelQ    <= levelD;
            rdQ       <= rdD;
            topQ      <= topD;
            botQ      <= botD;
            cIrqQ     <= cIrqD;
            oIrqQ     <= oIrqD;
        end
    end

    assign regRdData   = rdQ;
    assign captureIrq  = cIrqQ;
    assign overflowIrq = oIrqQ;
    assign atTop       = topQ;
    assign atBottom    = botQ;

    a_capture_copies_count: assert property (@(posedge clk_sys)
        disable iff (reset) (captEdge && !(regWrite
        && regAddr == tcc_pkg::ADDR_CAPT_LOW))
        |=> (captQ == $past(countQ)) && captFlagQ)
        else $error("capture did not store count and flag");
    a_write_beats_count: assert property (@(posedge clk_sys)
        disable iff (reset) (regWrite && regAddr == tcc_pkg::ADDR_COUNT_LOW)
        |=> countQ == {$past(tempQ), $past(regWrData)})
        else $error("count write lost to counting");
    a_stopped_holds: assert property (@(posedge clk_sys)
        disable iff (reset) (ctrlBQ[2:0] == 3'h0 && !regWrite)
        |=> countQ == $past(countQ))
        else $error("counter moved with no clock selected");
    a_no_tick_holds: assert property (@(posedge clk_sys)
        disable iff (reset) (!timerTick && !regWrite)
        |=> $stable(countQ))
        else $error("counter moved without a tick");
    a_low_read_temp: assert property (@(posedge clk_sys)
        disable iff (reset) (regRead && regAddr == tcc_pkg::ADDR_CAPT_LOW)
        ##2 (regRead && regAddr == tcc_pkg::ADDR_CAPT_HIGH)
        |=> regRdData == $past(captQ[15:8], 3))
        else $error("capture high byte not from temp");
    a_capt_write_gate: assert property (@(posedge clk_sys)
        disable iff (reset) (regWrite && regAddr == tcc_pkg::ADDR_CAPT_LOW
        && !tcc_pkg::tcc_capt_is_top(wgm) && !captEdge)
        |=> $stable(captQ))
        else $error("capture written outside top modes");
    a_flag_clear_one: assert property (@(posedge clk_sys)
        disable iff (reset) (captFlagQ && captureIrqAck && !captEdge)
        |=> !captFlagQ)
        else $error("capture flag not cleared on service");
    a_irq_follows_flag: assert property (@(posedge clk_sys)
        disable iff (reset) captureIrq
        |-> $past(captFlagD) && $past(maskD[tcc_pkg::CAPT_BIT]))
        else $error("capture irq without enabled flag");
    a_no_edge_top_mode: assert property (@(posedge clk_sys)
        disable iff (reset) (tcc_pkg::tcc_capt_is_top(wgm)
        && $past(tcc_pkg::tcc_capt_is_top(wgm))) |-> $stable(edgeBus.level))
        else $error("capture edge in capture-top mode");
endmodule // tcc_timer

// File: testbench/tcc_cpu_model.sv
// cpu side of the 8-bit register port: byte and 16-bit access tasks
// assumes the timer answers a read in the cycle after the strobe
`timescale 1ns/100ps
module tcc_cpu_model
(
    input  wire logic       clk_sys,
    output logic      [3:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrite,
    output logic            regRead,
    input  wire logic [7:0] regRdData
);
    initial
    begin
        regAddr   = 4'h0;
        regWrData = 8'h00;
        regWrite  = 1'b0;
        regRead   = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk_sys);
        regWrite  <= 1'b0;
        // idle bus shows no stale data
        regWrData <= ~d;
        regAddr   <= ~a;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData;
    endtask

    // high byte first, low byte commits both
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask

    // low byte first, it loads the shared high byte
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 4'h1, v[15:8]);
    endtask
endmodule // tcc_cpu_model

// File: testbench/tb_timer16_counter_input_capture.sv
// self-checking bench for the 16-bit timer counter with input capture
// assumes tcc_pkg and the cpu model are compiled first
`timescale 1ns/100ps
module tb_timer16_counter_input_capture;
    logic        clk_sys;
    logic        reset;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regRdData;
    logic        timerTick;
    logic        captureInputPin;
    logic        comparatorOutput;
    logic        captureIrqAck;
    logic        captureIrq;
    logic        overflowIrq;
    logic        atTop;
    logic        atBottom;
    int          failures;
    int          cmpCount;
    int          lat0;
    int          lat1;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] rv;
    logic [7:0]  b;

    tcc_timer u_dut
    (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .regAddr          (regAddr),
        .regWrData        (regWrData),
        .regWrite         (regWrite),
        .regRead          (regRead),
        .regRdData        (regRdData),
        .timerTick        (timerTick),
        .captureInputPin  (captureInputPin),
        .comparatorOutput (comparatorOutput),
        .captureIrqAck    (captureIrqAck),
        .captureIrq       (captureIrq),
        .overflowIrq      (overflowIrq),
        .atTop            (atTop),
        .atBottom         (atBottom)
    );

    tcc_cpu_model u_cpu
    (
        .clk_sys   (clk_sys),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWrite  (regWrite),
        .regRead   (regRead),
        .regRdData (regRdData)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", failures, cmpCount);
        if (failures == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [15:0] expTop(input logic [3:0] m);
        case (m)
            4'h1, 4'h5: return 16'h00FF;
            4'h2, 4'h6: return 16'h01FF;
            4'h3, 4'h7: return 16'h03FF;
            default:    return 16'hFFFF;
        endcase
    endfunction

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            timerTick <= 1'b1;
            @(posedge clk_sys);
            timerTick <= 1'b0;
        end
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic setMode(input logic [3:0] m, input logic [2:0] cs,
                           input logic edg, input logic flt);
        u_cpu.wr(tcc_pkg::ADDR_CTRL_A, {6'h00, m[1:0]});
        u_cpu.wr(tcc_pkg::ADDR_CTRL_B, {flt, edg, 1'b0, m[3:2], cs});
    endtask

    // moves the pin, then counts cycles until the capture irq shows
    task automatic pinTo(input logic lvl, output int lat);
        @(posedge clk_sys);
        captureInputPin <= lvl;
        lat = 0;
        while (captureIrq !== 1'b1 && lat < 20)
        begin
            @(posedge clk_sys);
            #1;
            lat++;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end

    initial
    begin
        failures = 0;
        cmpCount = 0;
        reset = 1'b1;
        timerTick = 1'b0;
        captureInputPin = 1'b0;
        comparatorOutput = 1'b0;
        captureIrqAck = 1'b0;
        void'($urandom(73));
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        check(atBottom, 16'h1);
        check({atTop, captureIrq, overflowIrq}, 16'h0);
        u_cpu.rd(tcc_pkg::ADDR_CTRL_B, b);
        check(b, tcc_pkg::CTRL_RESET);
        u_cpu.rd(4'hF, b);
        check(b, tcc_pkg::READ_NONE);
        repeat (6)
        begin
            v = 16'($urandom);
            u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, v);
            tick(3);
            u_cpu.rd16(tcc_pkg::ADDR_COUNT_LOW, rv);
            check(rv, v);
        end
        setMode(4'h0, 3'h1, 1'b1, 1'b0);
        u_cpu.wr(tcc_pkg::ADDR_IRQ_MASK, 8'h21);
        v = 16'($urandom_range(16'hFF00));
        lat0 = $urandom_range(9, 1);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, v);
        tick(lat0);
        u_cpu.rd16(tcc_pkg::ADDR_COUNT_LOW, rv);
        check(rv, v + 16'(lat0));
        v = 16'($urandom);
        u_cpu.wr(tcc_pkg::ADDR_COUNT_HIGH, v[15:8]);
        fork
            u_cpu.wr(tcc_pkg::ADDR_COUNT_LOW, v[7:0]);
            tick(1);
        join
        u_cpu.rd16(tcc_pkg::ADDR_COUNT_LOW, rv);
        check(rv, v);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, 16'hFFFE);
        tick(1);
        settle();
        check(atTop, 16'h1);
        tick(1);
        settle();
        check({atBottom, overflowIrq}, 16'h3);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h01);
        u_cpu.rd(tcc_pkg::ADDR_FLAGS, b);
        check(b[tcc_pkg::OVF_BIT], 16'h0);
        setMode(4'h1, 3'h1, 1'b1, 1'b0);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, 16'h00FE);
        tick(2);
        u_cpu.rd16(tcc_pkg::ADDR_COUNT_LOW, rv);
        check(rv, 16'h00FE);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, 16'h0001);
        tick(2);
        settle();
        check(overflowIrq, 16'h1);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h01);
        for (int m = 0; m < 16; m++)
        begin
            if (!(m inside {8, 10, 12, 14}))
            begin
                setMode(m[3:0], 3'h0, 1'b1, 1'b0);
                u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, expTop(m[3:0]));
                settle();
                check(atTop, 16'h1);
            end
        end
        setMode(4'h0, 3'h0, 1'b1, 1'b0);
        v = 16'($urandom);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, v);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h21);
        pinTo(1'b1, lat0);
        check(captureIrq, 16'h1);
        u_cpu.rd16(tcc_pkg::ADDR_CAPT_LOW, rv);
        check(rv, v);
        w = 16'($urandom);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, w);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        pinTo(1'b0, lat1);
        pinTo(1'b1, lat1);
        u_cpu.rd16(tcc_pkg::ADDR_CAPT_LOW, rv);
        check(rv, w);
        setMode(4'h0, 3'h0, 1'b0, 1'b0);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        settle();
        check(captureIrq, 16'h0);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, v);
        pinTo(1'b0, lat1);
        u_cpu.rd16(tcc_pkg::ADDR_CAPT_LOW, rv);
        check(rv, v);
        @(posedge clk_sys);
        captureIrqAck <= 1'b1;
        @(posedge clk_sys);
        captureIrqAck <= 1'b0;
        settle();
        check(captureIrq, 16'h0);
        setMode(4'h0, 3'h0, 1'b1, 1'b1);
        @(posedge clk_sys);
        captureInputPin <= 1'b1;
        repeat (2) @(posedge clk_sys);
        captureInputPin <= 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        check(captureIrq, 16'h0);
        pinTo(1'b1, lat1);
        check(lat1 - lat0, 16'(tcc_pkg::FILT_SAMPLES));
        u_cpu.wr(tcc_pkg::ADDR_CMP_CTRL, 8'h04);
        setMode(4'h0, 3'h0, 1'b1, 1'b0);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        pinTo(1'b0, lat1);
        pinTo(1'b1, lat1);
        check(captureIrq, 16'h0);
        @(posedge clk_sys);
        comparatorOutput <= 1'b1;
        settle();
        repeat (6) @(posedge clk_sys);
        #1;
        check(captureIrq, 16'h1);
        u_cpu.wr(tcc_pkg::ADDR_CMP_CTRL, 8'h00);
        setMode(4'hC, 3'h0, 1'b1, 1'b0);
        u_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        w = 16'($urandom);
        u_cpu.wr(tcc_pkg::ADDR_CAPT_HIGH, w[15:8]);
        u_cpu.wr(tcc_pkg::ADDR_CAPT_LOW, w[7:0]);
        u_cpu.wr(tcc_pkg::ADDR_COUNT_LOW, ~w[7:0]);
        u_cpu.rd16(tcc_pkg::ADDR_CAPT_LOW, rv);
        check(rv, w);
        u_cpu.rd16(tcc_pkg::ADDR_COUNT_LOW, rv);
        check(rv, {w[15:8], ~w[7:0]});
        pinTo(1'b0, lat1);
        pinTo(1'b1, lat1);
        check(captureIrq, 16'h0);
        u_cpu.wr16(tcc_pkg::ADDR_COUNT_LOW, w);
        settle();
        check(atTop, 16'h1);
        setMode(4'h0, 3'h0, 1'b1, 1'b0);
        u_cpu.wr16(tcc_pkg::ADDR_CAPT_LOW, ~w);
        u_cpu.rd16(tcc_pkg::ADDR_CAPT_LOW, rv);
        check(rv, w);
        print_verdict();
    end
endmodule // tb_timer16_counter_input_capture
